// ---- shared/bbf_cyc_if.sv ----
// Purpose: Link between the sequencer and the bus cycle engine.
// Assumes: One cycle request at a time, held until done.
// Notes: Write carries data; read returns data on done.
interface bbf_cyc_if;
    logic req;
    logic is_write;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport seq (output req, output is_write, output addr, output wdata,
                 input done, input rdata);
    modport eng (input req, input is_write, input addr, input wdata,
                 output done, output rdata);
endinterface : bbf_cyc_if

// ---- shared/bbf_pkg.sv ----
// Purpose: Constants and types shared by the boot block flash host controller.
// Assumes: 100 MHz clock, one flash bus cycle built from a few clock cycles.
// Notes: Boot-block address window and identify command code are parameters.
package bbf_pkg;
    localparam int unsigned BBF_CLK_MHZ = 100;
    // Strobe low time and setup/hold time, in nanoseconds.
    localparam int unsigned BBF_STROBE_NS = 50;
    localparam int unsigned BBF_SETUP_NS = 20;
    localparam int unsigned BBF_STROBE_CYC =
        (BBF_STROBE_NS * BBF_CLK_MHZ + 999) / 1000;
    localparam int unsigned BBF_SETUP_CYC =
        (BBF_SETUP_NS * BBF_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] BBF_STROBE_CNT = 4'(BBF_STROBE_CYC);
    localparam logic [3:0] BBF_SETUP_CNT = 4'(BBF_SETUP_CYC);
    localparam logic [7:0] BBF_CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] BBF_CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] BBF_CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] BBF_CMD_WRITE_SETUP_ALT = 8'h10;
    localparam logic [7:0] BBF_CMD_READ_ARRAY = 8'hFF;
    // Identify command code; value is arbitrary, set for the target part.
    localparam logic [7:0] BBF_CMD_IDENTIFY = 8'h90;
    localparam int unsigned BBF_ADDR_W = 18;
    localparam logic [BBF_ADDR_W-1:0] BBF_ADDR_ZERO = 18'h00000;
    localparam logic [BBF_ADDR_W-1:0] BBF_ID_CODE_ADDR = 18'h00001;
    // Host operations.
    typedef enum logic [2:0] {
        BBF_OP_READ,
        BBF_OP_WRITE,
        BBF_OP_ERASE,
        BBF_OP_READ_ARRAY,
        BBF_OP_IDENTIFY
    } bbf_op_t;
endpackage : bbf_pkg

// ---- sim/bbf_flash_model.sv ----
// Purpose: Pin-level model of the boot block flash that the host drives.
// Assumes: Program and erase finish at once; status reads say ready.
// Notes: Identity values are arbitrary; released lines show a pattern.
module bbf_flash_model #(
    parameter logic [17:0] BOOT_LO = 18'h00000,
    parameter logic [17:0] BOOT_HI = 18'h01FFF,
    parameter bit TOP_BOOT = 1'b0,
    // Arbitrary identity values, not those of any real part.
    parameter logic [7:0] MFG_CODE = 8'h3C,
    parameter logic [7:0] DEV_TOP = 8'h5B,
    parameter logic [7:0] DEV_BOT = 8'h5C,
    parameter logic [7:0] ID_UPPER = 8'h1E
) (
    // Control pins
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic byte_mode_n,
    input wire logic power_down_reset_n,
    input wire logic boot_unlock_voltage_en,
    input wire logic boot_protect_high,
    input wire logic prog_supply_en,
    // Address and data
    input wire logic [17:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic [15:0] flash_dq_oe,
    output logic [15:0] dq_level,
    // Host faults seen
    output logic bus_fault,
    output logic id_addr_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [1:0] {BBFM_ARRAY, BBFM_ID, BBFM_STATUS} bbfm_mode_t;
    logic [15:0] mem [0:262143];
    bbfm_mode_t mode;
    logic [1:0] pend;
    logic [15:0] d, word, dev_out;
    logic flip, dev_en, x8, ok;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 262144; i++) mem[i] = 16'hFFFF;
        mode = BBFM_ARRAY;
        pend = 2'h0;
        flip = 1'b0;
        bus_fault = 1'b0;
        id_addr_fault = 1'b0;
    end
    // Undriven lines wander so a stale value is never mistaken for data.
    always #5 flip = ~flip;
    assign x8 = !byte_mode_n;
    assign ok = prog_supply_en && (flash_addr < BOOT_LO ||
        flash_addr > BOOT_HI || boot_protect_high ||
        boot_unlock_voltage_en);
    always @* begin
        word = mem[flash_addr];
        dev_en = power_down_reset_n && !chip_sel_n && !out_en_n;
        case (mode)
            BBFM_ID: dev_out = {ID_UPPER, flash_addr[0] ? (TOP_BOOT ? DEV_TOP :
                DEV_BOT) : MFG_CODE};
            BBFM_STATUS: dev_out = 16'h0080;
            default: dev_out = x8 ? {8'h00, flash_dq_out[15] ? word[15:8] :
                word[7:0]} : word;
        endcase
        for (int i = 0; i < 16; i++) begin
            if (flash_dq_oe[i])
                dq_level[i] = flash_dq_out[i];
            else if (dev_en && (i < 8 || !x8))
                dq_level[i] = dev_out[i];
            else
                dq_level[i] = flip ^ i[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always @(posedge write_n or negedge power_down_reset_n) begin
        if (!power_down_reset_n) begin
            mode = BBFM_ARRAY;
            pend = 2'h0;
        end else if (!chip_sel_n) begin
            d = flash_dq_out;
            if (pend == 2'h1) begin
                if (d[7:0] == 8'hD0 && ok)
                    for (int i = 0; i < 8192; i++)
                        mem[{flash_addr[17:13], 13'(i)}] = 16'hFFFF;
                mode = BBFM_STATUS;
                pend = 2'h0;
            end else if (pend == 2'h2) begin
                if (ok && !x8) mem[flash_addr] = mem[flash_addr] & d;
                else if (ok && d[15])
                    mem[flash_addr][15:8] = mem[flash_addr][15:8] & d[7:0];
                else if (ok)
                    mem[flash_addr][7:0] = mem[flash_addr][7:0] & d[7:0];
                mode = BBFM_STATUS;
                pend = 2'h0;
            end else begin
                case (d[7:0])
                    8'h20: pend = 2'h1;
                    8'h40, 8'h10: pend = 2'h2;
                    8'hFF: mode = BBFM_ARRAY;
                    8'h90: mode = BBFM_ID;
                    default: ;
                endcase
            end
        end
    end
    always @(negedge write_n) if (!chip_sel_n && !out_en_n) bus_fault = 1'b1;
    always @(negedge out_en_n)
        if (!chip_sel_n && mode == BBFM_ID && flash_addr[17:1] != 17'h0)
            id_addr_fault = 1'b1;
endmodule // bbf_flash_model

// ---- sim/bbf_host_test.sv ----
// Purpose: Self-checking bench of the boot block flash host controller.
// Assumes: Model finishes program and erase before the next request.
// Notes: Byte reads are judged on the low byte only.
module bbf_host_test;
    import bbf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary identity values, the same as the model is given.
    localparam logic [7:0] MFG = 8'h3C;
    localparam logic [7:0] DEVB = 8'h5C;
    localparam logic [7:0] UPR = 8'h1E;
    logic clk, sys_rst, op_valid, op_ready, op_byte_lsb, byte_mode, rd_valid;
    logic boot_refused, chip_sel_n, out_en_n, write_n, byte_mode_n, pd_n;
    logic unlock_en, protect_high, supply_en, idhv_en, bus_fault, id_fault;
    bbf_op_t op_code;
    logic [17:0] op_addr, flash_addr;
    logic [15:0] op_wdata, rd_data, dq_in, dq_out, dq_oe, rd;
    int n_fail = 0;
    int checks_done = 0;
    bbf_host bbf_host_inst (.clk(clk), .sys_rst(sys_rst),
        .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
        .op_addr(op_addr), .op_wdata(op_wdata), .op_byte_lsb(op_byte_lsb),
        .byte_mode(byte_mode), .rd_valid(rd_valid), .rd_data(rd_data),
        .boot_refused(boot_refused), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_n(write_n), .byte_mode_n(byte_mode_n),
        .power_down_reset_n(pd_n), .boot_unlock_voltage_en(unlock_en),
        .boot_protect_high(protect_high), .prog_supply_en(supply_en),
        .id_select_high_voltage_en(idhv_en), .flash_addr(flash_addr),
        .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
    bbf_flash_model #(.MFG_CODE(MFG), .DEV_BOT(DEVB), .ID_UPPER(UPR))
    bbf_flash_model_inst (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_n(write_n), .byte_mode_n(byte_mode_n),
        .power_down_reset_n(pd_n), .boot_unlock_voltage_en(unlock_en),
        .boot_protect_high(protect_high), .prog_supply_en(supply_en),
        .flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .dq_level(dq_in), .bus_fault(bus_fault), .id_addr_fault(id_fault));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Runs one request; reads return once rd_valid pulses.
    task automatic run(input bbf_op_t op, input logic [17:0] a,
            input logic [15:0] d, input logic lsb);
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        op_valid = 1'b1;
        op_code = op;
        op_addr = a;
        op_wdata = d;
        op_byte_lsb = lsb;
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        n = 0;
        while (n < 300 && ((op == BBF_OP_READ || op == BBF_OP_IDENTIFY) ?
                rd_valid !== 1'b1 : op_ready !== 1'b1)) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n < 300), 16'h1);
        rd = rd_data;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_word();
        run(BBF_OP_WRITE, 18'h04010, 16'h1234, 1'b0);
        run(BBF_OP_READ_ARRAY, 18'h00000, 16'h0000, 1'b0);
        run(BBF_OP_READ, 18'h04010, 16'h0000, 1'b0);
        check(rd, 16'h1234);
        run(BBF_OP_READ, 18'h04011, 16'h0000, 1'b0);
        check(rd, 16'hFFFF);
    endtask
    task automatic t_erase();
        run(BBF_OP_WRITE, 18'h04020, 16'hA55A, 1'b0);
        run(BBF_OP_WRITE, 18'h06000, 16'h0F0F, 1'b0);
        run(BBF_OP_ERASE, 18'h04000, 16'h0000, 1'b0);
        run(BBF_OP_READ, 18'h04020, 16'h0000, 1'b0);
        check(rd, 16'hFFFF);
        run(BBF_OP_READ, 18'h06000, 16'h0000, 1'b0);
        check(rd, 16'h0F0F);
    endtask
    task automatic t_boot();
        run(BBF_OP_WRITE, 18'h00100, 16'hBEEF, 1'b0);
        run(BBF_OP_READ, 18'h00100, 16'h0000, 1'b0);
        check(rd, 16'hBEEF);
        run(BBF_OP_ERASE, 18'h00000, 16'h0000, 1'b0);
        run(BBF_OP_READ, 18'h00100, 16'h0000, 1'b0);
        check(rd, 16'hFFFF);
        check({15'h0, boot_refused}, 16'h0);
    endtask
    task automatic t_byte();
        byte_mode = 1'b1;
        run(BBF_OP_WRITE, 18'h05000, 16'h00C3, 1'b1);
        run(BBF_OP_WRITE, 18'h05000, 16'h005A, 1'b0);
        check({15'h0, byte_mode_n}, 16'h0);
        run(BBF_OP_READ, 18'h05000, 16'h0000, 1'b1);
        check({8'h00, rd[7:0]}, 16'h00C3);
        run(BBF_OP_READ, 18'h05000, 16'h0000, 1'b0);
        check({8'h00, rd[7:0]}, 16'h005A);
        byte_mode = 1'b0;
        run(BBF_OP_READ, 18'h05000, 16'h0000, 1'b0);
        check(rd, 16'hC35A);
    endtask
    task automatic t_ident();
        run(BBF_OP_IDENTIFY, 18'h00000, 16'h0000, 1'b0);
        check(rd, {UPR, MFG});
        run(BBF_OP_IDENTIFY, 18'h00001, 16'h0000, 1'b0);
        check(rd, {UPR, DEVB});
        byte_mode = 1'b1;
        run(BBF_OP_IDENTIFY, 18'h00001, 16'h0000, 1'b0);
        check({8'h00, rd[7:0]}, {8'h00, DEVB});
        byte_mode = 1'b0;
        check({15'h0, id_fault}, 16'h0);
        check({14'h0, idhv_en, unlock_en}, 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial begin
        sys_rst = 1'b1;
        op_valid = 1'b0;
        op_code = BBF_OP_READ;
        op_addr = 18'h00000;
        op_wdata = 16'h0000;
        op_byte_lsb = 1'b0;
        byte_mode = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({14'h0, chip_sel_n, pd_n}, 16'h2);
        repeat (7) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_word();
        t_erase();
        t_boot();
        t_byte();
        t_ident();
        check({15'h0, bus_fault}, 16'h0);
        summarize();
    end
endmodule // bbf_host_test

// ---- src/bbf_cycle.sv ----
// Purpose: Drives one flash bus read or write cycle on the pins.
// Assumes: Flash inputs synchronous to clk; byte mode chosen by the top.
// Notes: Write data is latched by the flash at the rising write strobe.
module bbf_cycle
    import bbf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Sequencer side
    bbf_cyc_if.eng cyc,
    input wire logic byte_mode,
    // Flash pins
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic [17:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic [15:0] flash_dq_oe
);
    import bbf_pkg::*;

    typedef enum logic [1:0] {BBF_C_IDLE, BBF_C_SETUP, BBF_C_STROBE,
                              BBF_C_HOLD} bbf_cst_t;
    typedef struct packed {
        bbf_cst_t st;
        logic [3:0] cnt;
        logic wr;
        logic done;
        logic [15:0] rdata;
        logic [17:0] addr;
        logic [15:0] dout;
    } bbf_cyc_state_t;

    bbf_cyc_state_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            BBF_C_IDLE: begin
                if (cyc.req && !s_reg.done) begin
                    s_next.st = BBF_C_SETUP;
                    s_next.cnt = BBF_SETUP_CNT;
                    s_next.wr = cyc.is_write;
                    s_next.addr = cyc.addr;
                    s_next.dout = cyc.wdata;
                end
            end
            BBF_C_SETUP: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.st = BBF_C_STROBE;
                    s_next.cnt = BBF_STROBE_CNT;
                end
            end
            BBF_C_STROBE: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.st = BBF_C_HOLD;
                    s_next.cnt = BBF_SETUP_CNT;
                    s_next.rdata = flash_dq_in;
                end
            end
            BBF_C_HOLD: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.st = BBF_C_IDLE;
                    s_next.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Chip select spans the whole cycle; strobes only the middle phase.
    assign chip_sel_n = (s_reg.st == BBF_C_IDLE);
    assign write_n = !(s_reg.wr && s_reg.st == BBF_C_STROBE);
    assign out_en_n = !(!s_reg.wr && s_reg.st == BBF_C_STROBE);
    assign flash_addr = s_reg.addr;
    assign flash_dq_out = s_reg.dout;
    // In byte mode the top line carries the lowest address bit instead.
    assign flash_dq_oe = (s_reg.wr && s_reg.st != BBF_C_IDLE) ?
        (byte_mode ? 16'h80FF : 16'hFFFF) :
        ((s_reg.st != BBF_C_IDLE && byte_mode) ? 16'h8000 : 16'h0000);
    assign cyc.done = s_reg.done;
    assign cyc.rdata = s_reg.rdata;

    AST_NO_BOTH_STROBES: assert property (@(posedge clk) disable iff (sys_rst)
        !(!write_n && !out_en_n))
        else $error("write strobe and output enable both low");
    AST_STROBE_IN_SELECT: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(write_n) |-> !chip_sel_n [*2])
        else $error("write strobe without chip select");
endmodule // bbf_cycle

// ---- src/bbf_host.sv ----
// Purpose: Host controller that runs command sequences on a boot block flash.
// Assumes: Inputs synchronous to clk; supply and unlock voltage driven by
//          board switches steered from the enables below.
// Notes: Device completion is not polled; the user waits for status itself.
module bbf_host
    import bbf_pkg::*;
#(
    parameter logic [17:0] BOOT_LO = 18'h00000,
    parameter logic [17:0] BOOT_HI = 18'h01FFF
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // User request
    input wire logic op_valid,
    output logic op_ready,
    input wire bbf_pkg::bbf_op_t op_code,
    input wire logic [17:0] op_addr,
    input wire logic [15:0] op_wdata,
    input wire logic op_byte_lsb,
    input wire logic byte_mode,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic boot_refused,
    // Flash control pins
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic byte_mode_n,
    output logic power_down_reset_n,
    output logic boot_unlock_voltage_en,
    output logic boot_protect_high,
    output logic prog_supply_en,
    output logic id_select_high_voltage_en,
    // Flash address and data
    output logic [17:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic [15:0] flash_dq_oe
);
    import bbf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {BBF_S_IDLE, BBF_S_CMD1, BBF_S_CMD2,
                              BBF_S_READ, BBF_S_DONE} bbf_hst_t;
    typedef struct packed {
        bbf_hst_t st;
        bbf_op_t op;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic lsb;
        logic boot;
        logic array_stale;
        logic rd_valid;
        logic [15:0] rd_data;
        logic refused;
        logic pd_n;
        logic rd_after;
    } bbf_host_state_t;

    bbf_host_state_t s_reg, s_next;
    bbf_cyc_if cyc();

    function automatic logic in_boot(input logic [17:0] a);
        in_boot = (a >= BOOT_LO) && (a <= BOOT_HI);
    endfunction

    function automatic logic [15:0] cmd_word(input logic [7:0] c);
        cmd_word = {8'h00, c};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.rd_valid = 1'b0;
        s_next.refused = 1'b0;
        s_next.pd_n = 1'b1;
        cyc.req = 1'b0;
        cyc.is_write = 1'b1;
        cyc.addr = s_reg.addr;
        cyc.wdata = s_reg.wdata;
        unique case (s_reg.st)
            BBF_S_IDLE: begin
                if (op_valid) begin
                    s_next.op = op_code;
                    s_next.addr = op_addr;
                    s_next.wdata = op_wdata;
                    s_next.lsb = op_byte_lsb;
                    s_next.boot = in_boot(op_addr);
                    // Remember the user's intent; op_code may move on.
                    s_next.rd_after = (op_code == BBF_OP_READ);
                    // Reads of stale array data are turned into a
                    // read-array command first.
                    if (op_code == BBF_OP_READ && s_reg.array_stale) begin
                        s_next.st = BBF_S_CMD1;
                        s_next.op = BBF_OP_READ_ARRAY;
                    end else if (op_code == BBF_OP_READ) begin
                        s_next.st = BBF_S_READ;
                    end else begin
                        s_next.st = BBF_S_CMD1;
                    end
                end
            end
            BBF_S_CMD1: begin
                cyc.req = 1'b1;
                cyc.addr = BBF_ADDR_ZERO;
                unique case (s_reg.op)
                    BBF_OP_ERASE: cyc.wdata = cmd_word(BBF_CMD_ERASE_SETUP);
                    BBF_OP_WRITE: cyc.wdata = cmd_word(BBF_CMD_WRITE_SETUP);
                    BBF_OP_IDENTIFY: cyc.wdata = cmd_word(BBF_CMD_IDENTIFY);
                    default: cyc.wdata = cmd_word(BBF_CMD_READ_ARRAY);
                endcase
                if (cyc.done) begin
                    unique case (s_reg.op)
                        BBF_OP_ERASE, BBF_OP_WRITE: s_next.st = BBF_S_CMD2;
                        BBF_OP_IDENTIFY: begin
                            s_next.st = BBF_S_READ;
                            s_next.array_stale = 1'b1;
                        end
                        BBF_OP_READ_ARRAY: begin
                            s_next.array_stale = 1'b0;
                            s_next.st = s_reg.rd_after ?
                                BBF_S_READ : BBF_S_DONE;
                            s_next.op = BBF_OP_READ;
                        end
                        default: s_next.st = BBF_S_DONE;
                    endcase
                end
            end
            BBF_S_CMD2: begin
                cyc.req = 1'b1;
                if (s_reg.op == BBF_OP_ERASE) begin
                    cyc.wdata = cmd_word(BBF_CMD_ERASE_CONFIRM);
                end else if (byte_mode) begin
                    // Byte data on the low lane, lsb on the top line.
                    cyc.wdata = {s_reg.lsb, 7'h00, s_reg.wdata[7:0]};
                end else begin
                    cyc.wdata = s_reg.wdata;
                end
                if (cyc.done) begin
                    s_next.st = BBF_S_DONE;
                    s_next.array_stale = 1'b1;
                end
            end
            BBF_S_READ: begin
                cyc.req = 1'b1;
                cyc.is_write = 1'b0;
                if (byte_mode) begin
                    // The top line carries the byte select on reads too.
                    cyc.wdata = {s_reg.lsb, 15'h0000};
                end
                // Identify reads keep all lines low except bit zero.
                if (s_reg.op == BBF_OP_IDENTIFY) begin
                    cyc.addr = s_reg.addr[0] ? BBF_ID_CODE_ADDR
                                             : BBF_ADDR_ZERO;
                end
                if (cyc.done) begin
                    s_next.st = BBF_S_IDLE;
                    s_next.rd_valid = 1'b1;
                    s_next.rd_data = byte_mode ?
                        {8'h00, cyc.rdata[7:0]} : cyc.rdata;
                end
            end
            BBF_S_DONE: begin
                s_next.st = BBF_S_IDLE;
            end
            default: s_next.st = BBF_S_IDLE;
        endcase
        if (sys_rst) begin
            s_next.pd_n = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    bbf_cycle u_cycle (
        .clk(clk),
        .sys_rst(sys_rst),
        .cyc(cyc),
        .byte_mode(byte_mode),
        .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n),
        .write_n(write_n),
        .flash_addr(flash_addr),
        .flash_dq_in(flash_dq_in),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Supplies are steered per operation; boot_protect_high is raised for the
    // whole second cycle of a boot-block operation so it is still up when the
    // write strobe rises.
    logic second_cyc;
    assign second_cyc = (s_reg.st == BBF_S_CMD2);
    assign op_ready = (s_reg.st == BBF_S_IDLE);
    assign rd_valid = s_reg.rd_valid;
    assign rd_data = s_reg.rd_data;
    assign boot_refused = s_reg.refused;
    assign byte_mode_n = !byte_mode;
    assign power_down_reset_n = s_reg.pd_n;
    assign prog_supply_en = second_cyc;
    assign boot_protect_high = second_cyc && s_reg.boot;
    assign boot_unlock_voltage_en = 1'b0;
    assign id_select_high_voltage_en = 1'b0;

    AST_CONFIRM_AFTER_SETUP: assert property (@(posedge clk)
        disable iff (sys_rst)
        (s_reg.st == BBF_S_CMD2 && s_reg.op == BBF_OP_ERASE)
        |-> $past(s_reg.st) inside {BBF_S_CMD1, BBF_S_CMD2})
        else $error("erase confirm without setup");
    AST_SUPPLY_IN_CMD2: assert property (@(posedge clk) disable iff (sys_rst)
        (second_cyc && !write_n) |=> prog_supply_en [*3])
        else $error("data cycle without program supply");
    AST_BOOT_UNLOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (second_cyc && !write_n && in_boot(flash_addr))
        |-> (boot_protect_high && prog_supply_en))
        else $error("boot write without unlock");
    AST_STALE_AFTER_PROG: assert property (@(posedge clk)
        disable iff (sys_rst)
        (second_cyc && cyc.done) |=> s_reg.array_stale)
        else $error("array not marked stale");
    AST_BYTE_LOW_LANE: assert property (@(posedge clk) disable iff (sys_rst)
        (byte_mode && !write_n) |-> flash_dq_oe[14:8] == 7'h00)
        else $error("middle lines driven in byte mode");
    AST_ID_ADDR_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        (s_reg.st == BBF_S_READ && s_reg.op == BBF_OP_IDENTIFY && !out_en_n)
        |-> flash_addr[17:1] == 17'h00000)
        else $error("identify address lines not low");
    AST_RESET_PD: assert property (@(posedge clk)
        sys_rst |=> !power_down_reset_n)
        else $error("power down not asserted");
    AST_READ_DONE: assert property (@(posedge clk) disable iff (sys_rst)
        (s_reg.st == BBF_S_READ && cyc.done) |=> rd_valid)
        else $error("read data not returned");
    COV_ERASE: cover property (@(posedge clk) second_cyc && !write_n &&
        s_reg.op == BBF_OP_ERASE);
    COV_PROG: cover property (@(posedge clk) second_cyc && !write_n &&
        s_reg.op == BBF_OP_WRITE);
    COV_ID: cover property (@(posedge clk) rd_valid &&
        s_reg.op == BBF_OP_IDENTIFY);
endmodule // bbf_host
